// file: core/sram_host_pkg.sv
// constants for the battery-backed static memory host controller
package sram_host_pkg;
	localparam int ADDR_W = 19;                 // address lines
	localparam int DATA_W = 8;                  // data lines
	localparam int CLK_PERIOD_NS = 40;          // 25 MHz
	// read timing, ns
	localparam int ADDRESS_ACCESS_TIME_NS = 85;
	localparam int SELECT_ACCESS_TIME_NS = 85;
	localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 45;
	// write timing, ns
	localparam int STROBE_PULSE_NS = 65;
	localparam int DATA_SETUP_TO_STROBE_END_NS = 35;
	localparam int STROBE_RELEASE_TO_ADDRESS_CHANGE_NS = 15;
	localparam int DATA_HOLD_AFTER_STROBE_END_NS = 10;
	// power-up recovery, us
	localparam int POWERUP_RECOVERY_TIME_US = 120;
	// derived cycle counts: least times round up
	localparam int READ_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (STROBE_RELEASE_TO_ADDRESS_CHANGE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RECOVERY_CYC = POWERUP_RECOVERY_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	typedef enum logic [2:0] {ST_RECOVER, ST_IDLE, ST_READ, ST_WRITE, ST_HOLD} state_t;
endpackage

// file: core/sram_host.sv
// host controller driving the battery-backed static memory pins
`timescale 1ns/10ps
module sram_host #(
	parameter int RECOVERY_CYCLES = sram_host_pkg::RECOVERY_CYC
) (
	input  wire logic                              clock_i,
	input  wire logic                              reset_i,
	input  wire logic                              req_valid_i,
	output logic                                   req_ready_o,
	input  wire logic                              req_write_i,
	input  wire logic [sram_host_pkg::ADDR_W-1:0]  req_addr_i,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  req_wdata_i,
	output logic                                   rsp_valid_o,
	output logic [sram_host_pkg::DATA_W-1:0]       rsp_rdata_o,
	input  wire logic                              power_good_i,
	output logic [sram_host_pkg::ADDR_W-1:0]       address_bus_o,
	output logic                                   select_n_o,
	output logic                                   output_enable_n_o,
	output logic                                   write_strobe_n_o,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  data_bus_i,
	output logic [sram_host_pkg::DATA_W-1:0]       data_bus_o,
	output logic                                   data_bus_oe_o
);
	import sram_host_pkg::*;

	state_t                state_q, state_d;
	logic [31:0]           rec_cnt_q;
	logic [CNT_W-1:0]      cnt_q;
	logic [ADDR_W-1:0]     addr_q;
	logic [DATA_W-1:0]     wdata_q;
	logic [DATA_W-1:0]     rdata_q;
	logic                  rsp_q;
	logic                  pg_meta_q, pg_q;
	logic [DATA_W-1:0]     dq_meta_q, dq_q;
	logic                  cnt_done;
	logic                  take;
	logic                  wdata_drive_q;

	// pins pass two flops before use
	always_ff @(posedge clock_i) begin
		pg_meta_q <= power_good_i;
		pg_q      <= pg_meta_q;
		dq_meta_q <= data_bus_i;
		dq_q      <= dq_meta_q;
	end

	// a new cycle only in idle with power good: after recovery, or after a cycle that ends with power good
	assign req_ready_o = (state_q == ST_IDLE) && pg_q;
	assign take        = req_valid_i && req_ready_o;
	assign cnt_done    = (cnt_q == '0);

	// next state; a started cycle always completes even if power fails
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RECOVER: if (rec_cnt_q == '0 && pg_q) state_d = ST_IDLE;
			// a supply drop while idle restarts recovery, so ready cannot skip it
			ST_IDLE: begin
				if (!pg_q) state_d = ST_RECOVER;
				else if (take) state_d = req_write_i ? ST_WRITE : ST_READ;
			end
			ST_READ: if (cnt_done) state_d = ST_HOLD;
			ST_WRITE: if (cnt_done) state_d = ST_HOLD;
			ST_HOLD: if (cnt_done) state_d = pg_q ? ST_IDLE : ST_RECOVER;
			default: state_d = ST_RECOVER;
		endcase
	end

	// state, counters and captured request
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q   <= ST_RECOVER;
			rec_cnt_q <= 32'(RECOVERY_CYCLES);
			cnt_q     <= '0;
			addr_q    <= '0;
			wdata_q   <= '0;
			rdata_q   <= '0;
			rsp_q     <= 1'b0;
		end else begin
			state_q <= state_d;
			rsp_q   <= 1'b0;
			// recovery restarts whenever supply drops
			if (!pg_q) rec_cnt_q <= 32'(RECOVERY_CYCLES);
			else if (rec_cnt_q != '0) rec_cnt_q <= rec_cnt_q - 32'd1;
			if (!cnt_done) cnt_q <= cnt_q - CNT_W'(1);
			if (take) begin
				addr_q  <= req_addr_i;
				wdata_q <= req_wdata_i;
				// read waits the access time plus two sync stages
				cnt_q   <= req_write_i ? CNT_W'(WRITE_CYC - 1) : CNT_W'(READ_CYC + 1);
			end
			if (state_q == ST_READ && cnt_done) begin
				rdata_q <= dq_q;
				rsp_q   <= 1'b1;
			end
			if ((state_q == ST_READ || state_q == ST_WRITE) && cnt_done)
				cnt_q <= CNT_W'(HOLD_CYC - 1);
		end
	end

	// pin drive: strobes from state, address held through the cycle
	assign address_bus_o     = addr_q;
	assign select_n_o        = !(state_q == ST_READ || state_q == ST_WRITE);
	assign write_strobe_n_o  = !(state_q == ST_WRITE);
	assign output_enable_n_o = !(state_q == ST_READ);
	// data driven through write and the hold after it
	assign data_bus_oe_o     = (state_q == ST_WRITE) || (state_q == ST_HOLD && write_strobe_n_o
		&& wdata_drive_q);
	assign data_bus_o        = wdata_q;
	assign rsp_valid_o       = rsp_q;
	assign rsp_rdata_o       = rdata_q;

	// remembers that the hold phase follows a write
	always_ff @(posedge clock_i) begin
		if (reset_i) wdata_drive_q <= 1'b0;
		else if (take) wdata_drive_q <= req_write_i;
	end

	property p_write_addr_stable;
		@(posedge clock_i) disable iff (reset_i)
		(!write_strobe_n_o && $past(!write_strobe_n_o)) |-> $stable(address_bus_o);
	endproperty
	a_write_addr_stable: assert property (p_write_addr_stable) else $error("address moved");

	property p_oe_high_in_write;
		@(posedge clock_i) disable iff (reset_i)
		!write_strobe_n_o |-> output_enable_n_o && data_bus_oe_o;
	endproperty
	a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("oe low in write");

	property p_hold_after_end;
		@(posedge clock_i) disable iff (reset_i)
		$rose(select_n_o) |-> select_n_o && req_ready_o == 1'b0;
	endproperty
	a_hold_after_end: assert property (p_hold_after_end) else $error("no hold gap");

	property p_data_after_write;
		@(posedge clock_i) disable iff (reset_i)
		$rose(write_strobe_n_o) |-> data_bus_oe_o && $stable(data_bus_o);
	endproperty
	a_data_after_write: assert property (p_data_after_write) else $error("data hold lost");

	property p_write_width;
		@(posedge clock_i) disable iff (reset_i)
		$fell(write_strobe_n_o) |-> !write_strobe_n_o [*2];
	endproperty
	a_write_width: assert property (p_write_width) else $error("strobe too short");

	property p_no_start_when_bad;
		@(posedge clock_i) disable iff (reset_i)
		(!pg_q && state_q == ST_IDLE) |=> select_n_o;
	endproperty
	a_no_start_when_bad: assert property (p_no_start_when_bad) else $error("start in bad power");

	property p_read_time;
		@(posedge clock_i) disable iff (reset_i)
		$fell(output_enable_n_o) |-> !output_enable_n_o [*5] ##1 rsp_valid_o;
	endproperty
	a_read_time: assert property (p_read_time) else $error("read timing");

	property p_recovery;
		@(posedge clock_i) disable iff (reset_i)
		$fell(pg_q) |=> !req_ready_o [*8];
	endproperty
	a_recovery: assert property (p_recovery) else $error("ready during recovery");

	// pin sequencing and handshake checks; the strobe must never be low outside a select
	property p_strobe_in_select;
		@(posedge clock_i) disable iff (reset_i)
		!write_strobe_n_o |-> !select_n_o;
	endproperty
	a_strobe_in_select: assert property (p_strobe_in_select) else $error("strobe alone");

	property p_no_drive_in_read;
		@(posedge clock_i) disable iff (reset_i)
		!output_enable_n_o |-> !data_bus_oe_o;
	endproperty
	a_no_drive_in_read: assert property (p_no_drive_in_read) else $error("bus fight");

	property p_rsp_pulse;
		@(posedge clock_i) disable iff (reset_i)
		rsp_valid_o |=> !rsp_valid_o;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");

	property p_bad_power_idle;
		@(posedge clock_i) disable iff (reset_i)
		!pg_q |=> !req_ready_o;
	endproperty
	a_bad_power_idle: assert property (p_bad_power_idle) else $error("ready in bad power");

	property p_write_data_stable;
		@(posedge clock_i) disable iff (reset_i)
		(!write_strobe_n_o && $past(!write_strobe_n_o)) |-> $stable(data_bus_o);
	endproperty
	a_write_data_stable: assert property (p_write_data_stable) else $error("data moved");

	property p_read_addr_stable;
		@(posedge clock_i) disable iff (reset_i)
		(!output_enable_n_o && $past(!output_enable_n_o)) |-> $stable(address_bus_o);
	endproperty
	a_read_addr_stable: assert property (p_read_addr_stable) else $error("read addr moved");
endmodule // sram_host

// file: tb/sram_dev_model.sv
// behavioural battery-backed memory device on the far side
`timescale 1ns/10ps
module sram_dev_model (
	input  wire logic        power_ok_i,
	input  wire logic [18:0] address_i,
	input  wire logic        select_n_i,
	input  wire logic        output_enable_n_i,
	input  wire logic        write_strobe_n_i,
	input  wire logic [7:0]  data_i,
	output logic [7:0]       data_o
);
	logic [7:0]  mem [logic [18:0]];
	logic [18:0] a_late;
	logic        s_late;
	logic [18:0] a_w;
	logic [7:0]  d_w;
	logic [7:0]  v;
	wire         wr = power_ok_i && !select_n_i && !write_strobe_n_i;
	wire         rd = power_ok_i && !select_n_i && !output_enable_n_i && write_strobe_n_i;
	// address and select must sit still for their access times before data counts
	always @(address_i) a_late <= #(sram_host_pkg::ADDRESS_ACCESS_TIME_NS) address_i;
	always @(select_n_i) s_late <= #(sram_host_pkg::SELECT_ACCESS_TIME_NS) select_n_i;
	// latch the last address and byte seen while writing
	always @* if (wr) begin
		a_w = address_i;
		d_w = data_i;
	end
	// the byte lands when the earlier strobe rises; repeats are unlimited
	always @(negedge wr) mem[a_w] = d_w;
	// an unsettled or floating bus shows the inverse, so a stale byte never passes
	always @* begin
		v = mem.exists(address_i) ? mem[address_i] : 8'h00;
		data_o = (rd && a_late === address_i && s_late === 1'b0) ? v : ~v;
	end
endmodule // sram_dev_model

// file: tb/battery_backed_sram_port_tb_top.sv
// self-checking bench for the memory host controller
`timescale 1ns/10ps
module battery_backed_sram_port_tb_top;
	import sram_host_pkg::*;
	logic clock_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0, power_good_i = 1;
	logic [ADDR_W-1:0] req_addr_i = 0, address_bus_o, a;
	logic [DATA_W-1:0] req_wdata_i = 0, rsp_rdata_o, data_bus_o, data_bus_i, dev_q, d;
	logic req_ready_o, rsp_valid_o, select_n_o, output_enable_n_o, write_strobe_n_o, data_bus_oe_o;
	logic [7:0] shadow [logic [18:0]];
	int fails = 0, n_checks = 0, k;
	assign data_bus_i = data_bus_oe_o ? data_bus_o : dev_q;
	sram_host #(.RECOVERY_CYCLES(4)) u_sram_host (.clock_i, .reset_i, .req_valid_i, .req_ready_o,
		.req_write_i, .req_addr_i, .req_wdata_i, .rsp_valid_o, .rsp_rdata_o, .power_good_i,
		.address_bus_o, .select_n_o, .output_enable_n_o, .write_strobe_n_o, .data_bus_i,
		.data_bus_o, .data_bus_oe_o);
	sram_dev_model u_sram_dev_model (.power_ok_i(power_good_i), .address_i(address_bus_o),
		.select_n_i(select_n_o), .output_enable_n_i(output_enable_n_o),
		.write_strobe_n_i(write_strobe_n_o), .data_i(data_bus_i), .data_o(dev_q));
	initial forever #20 clock_i = ~clock_i;
	function automatic logic [7:0] expect_rd(input logic [18:0] x);
		return shadow.exists(x) ? shadow[x] : 8'h00;
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait, looked at mid-cycle where the flag has settled
	task automatic wait_for(ref logic f, input int lim);
		k = 0;
		do begin
			@(negedge clock_i);
			k++;
		end while (f !== 1'b1 && k < lim);
		if (f !== 1'b1) begin
			fails++;
			end_sim();
		end
	endtask
	// one request, held until the edge that takes it
	task automatic op(input logic w, input logic [18:0] x, input logic [7:0] y);
		@(posedge clock_i);
		req_valid_i <= 1;
		req_write_i <= w;
		req_addr_i <= x;
		req_wdata_i <= y;
		wait_for(req_ready_o, 9000);
		@(posedge clock_i);
		req_valid_i <= 0;
		if (w) begin
			shadow[x] = y;
			@(negedge clock_i);
			check({output_enable_n_o, data_bus_oe_o, write_strobe_n_o, select_n_o}, 4'b1100);
			check(address_bus_o === x, 1);
			check(data_bus_o, y);
		end else begin
			wait_for(rsp_valid_o, 20);
			check(8'(k), 8'h06);
			check(rsp_rdata_o, expect_rd(x));
		end
	endtask
	initial begin
		void'($urandom(32'h30a46a2b));
		repeat (16) @(posedge clock_i);
		reset_i <= 0;
		// extreme addresses, then random traffic over a small pool to force reuse
		op(1, 19'h7ffff, 8'ha5);
		op(1, 19'h0, 8'h5a);
		op(0, 19'h7ffff, 0);
		op(0, 19'h0, 0);
		repeat (60) begin
			a = 19'($urandom) & 19'h6000f;
			d = 8'($urandom);
			op(1'($urandom), a, d);
		end
		// supply loss: controller must stop, then recover before new access
		@(posedge clock_i);
		power_good_i <= 0;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		check(req_ready_o, 0);
		check(select_n_o, 1);
		repeat (10) @(posedge clock_i);
		power_good_i <= 1;
		wait_for(req_ready_o, 50);
		check(k > 4, 1);
		op(0, 19'h7ffff, 0);
		end_sim();
	end
endmodule // battery_backed_sram_port_tb_top
